// ### fspm_pkg.sv
package fspm_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_PTR_LO = 8'h10;
  localparam logic [7:0] OFS_PTR_HI = 8'h14;
  localparam logic [7:0] OFS_CMP_LO = 8'h18;
  localparam logic [7:0] OFS_CMP_HI = 8'h1c;

  // ****************************************
  // codes and field positions
  // ****************************************
  localparam logic [7:0] KEY_VALUE = 8'ha5;
  localparam logic [7:0] MODE_SELF = 8'h01;
  localparam logic [7:0] MODE_NORMAL = 8'h00;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h03;
  localparam int ST_SEQ_ERR = 0;
  localparam int ST_VERIFY_ERR = 1;
  localparam int ST_WE_ERR = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_KEYED = 2'b01,
    SQ_VALUE = 2'b10,
    SQ_COMPL = 2'b11
  } fspm_seq_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_RUN = 2'b01,
    OP_DONE = 2'b10
  } fspm_op_t;
endpackage

// ### fspm_addr_ctr.sv
`timescale 1ns/1ps
module fspm_addr_ctr (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_ptr_lo,
  input wire logic wr_ptr_hi,
  input wire logic wr_cmp_lo,
  input wire logic wr_cmp_hi,
  input wire logic [7:0] wdata,
  input wire logic step,
  output logic [7:0] ptr_lo,
  output logic [7:0] ptr_hi,
  output logic [7:0] cmp_lo,
  output logic [7:0] cmp_hi,
  output logic match
);
  import fspm_pkg::*;

  // ****************************************
  // pointer counter and compare registers
  // ****************************************
  // the pointer is left at its last value after an operation,
  // so software reloads it before every command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_lo <= RST_PTR;
      ptr_hi <= RST_PTR;
    end else if (wr_ptr_lo) begin
      ptr_lo <= wdata;
    end else if (wr_ptr_hi) begin
      ptr_hi <= wdata;
    end else if (step) begin
      {ptr_hi, ptr_lo} <= 16'({ptr_hi, ptr_lo} + 16'h0001); // RULE19
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_lo <= RST_CMP;
      cmp_hi <= RST_CMP;
    end else begin
      if (wr_cmp_lo) begin
        cmp_lo <= wdata;
      end
      if (wr_cmp_hi) begin
        cmp_hi <= wdata;
      end
    end
  end

  assign match = ({ptr_hi, ptr_lo} == {cmp_hi, cmp_lo}); // RULE19

  a_step_increments: assert property (@(posedge clk) disable iff (rst)
    step && !wr_ptr_lo && !wr_ptr_hi |=>
      {ptr_hi, ptr_lo} == 16'($past({ptr_hi, ptr_lo}) + 16'h0001)) // RULE19
    else $error("pointer did not increment on step");
endmodule

// ### fspm_ctrl.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Function
// (RULE1) software writes key A5H to the key register before mode changes
// (RULE2) entry is 01H, 0FEH, 01H; first two writes change nothing
// (RULE3) self-programming mode starts only on the third correct write
// (RULE4) exit is 00H, 0FFH, 00H; first two writes change nothing
// (RULE5) normal mode returns only on the third correct exit write
// (RULE6) status bit 0 reports sequence failure; software clears and retries
// (RULE7) software clears the command register before a mode sequence
// (RULE8) software clears status before each sequence and each operation
// (RULE9) software masks all interrupts before entry, restores after exit
// (RULE10) cpu clock is at least 1 MHz before the entry sequence
// (RULE11) software runs a no-op then halt after the final entry write
// (RULE12) command code 03H means block erase
// (RULE13) software loads block number and compares for block erase
// (RULE14) halt in self-programming mode starts the operation; resume after
// (RULE15) status bit 1 verify failure, bit 2 write/erase or protect failure
// (RULE16) software restarts the watchdog just before an operation
// (RULE17) sequence code lives outside the area being erased
// (RULE18) software restores the cpu clock after a good exit
// (RULE19) pointers count up to the compare values; reload before commands
// (RULE20) undefined command ends at once and sets status bits 1 and 2
// (RULE21) software keeps bits 4 to 7 of high pointer and compare zero
// (RULE22) any access breaking the sequence order aborts it and flags error
module fspm_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fspm_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_req,
  input wire logic flash_done,
  input wire logic flash_err,
  input wire logic verify_err,
  output logic flash_erase,
  output logic [11:0] flash_addr,
  output logic cpu_resume,
  output logic self_prog_mode
);
  import fspm_pkg::*;

  // ****************************************
  // apb slave
  // ****************************************
  logic acc;
  logic wr;
  logic [7:0] wd;
  logic [7:0] flash_command_reg;
  logic [2:0] flash_status_reg;
  logic [7:0] ptr_lo;
  logic [7:0] ptr_hi;
  logic [7:0] cmp_lo;
  logic [7:0] cmp_hi;
  logic match;
  logic step;
  logic busy;
  fspm_seq_t seq;
  fspm_op_t op;
  logic [7:0] seq_value;
  logic seq_err_set;
  logic verify_set;
  logic we_set;

  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    return a == OFS_CMD || a == OFS_STATUS || a == OFS_KEY ||
      a == OFS_MODE || a == OFS_PTR_LO || a == OFS_PTR_HI ||
      a == OFS_CMP_LO || a == OFS_CMP_HI;
  endfunction

  function automatic logic hit(input logic [APB_AW-1:0] a,
                               input logic [7:0] ofs);
    return wr && a == ofs;
  endfunction

  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign wd = pwdata[7:0];
  assign busy = (op != OP_IDLE);

  // one wait-free answer: pready rises in the access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !is_mapped(paddr);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == OFS_CMD) begin
        prdata <= {24'h0, flash_command_reg};
      end else if (paddr == OFS_STATUS) begin
        prdata <= {29'h0, flash_status_reg};
      end else if (paddr == OFS_MODE) begin
        prdata <= {31'h0, self_prog_mode};
      end else if (paddr == OFS_PTR_LO) begin
        prdata <= {24'h0, ptr_lo};
      end else if (paddr == OFS_PTR_HI) begin
        prdata <= {24'h0, ptr_hi};
      end else if (paddr == OFS_CMP_LO) begin
        prdata <= {24'h0, cmp_lo};
      end else if (paddr == OFS_CMP_HI) begin
        prdata <= {24'h0, cmp_hi};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_command_reg <= RST_CMD;
    end else if (hit(paddr, OFS_CMD)) begin
      flash_command_reg <= wd;
    end
  end

  // ****************************************
  // protected mode-change sequence
  // ****************************************
  // any access except the expected next step aborts, reads included,
  // so an interrupt handler touching these registers cannot slip in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq <= SQ_IDLE;
      seq_value <= MODE_NORMAL;
      self_prog_mode <= 1'b0;
      seq_err_set <= 1'b0;
    end else begin
      seq_err_set <= 1'b0;
      if (acc) begin
        case (seq)
          SQ_IDLE: begin
            if (hit(paddr, OFS_KEY)) begin
              if (wd == KEY_VALUE) begin // RULE1
                seq <= SQ_KEYED;
              end else begin
                seq_err_set <= 1'b1; // RULE22
              end
            end else if (hit(paddr, OFS_MODE)) begin
              seq_err_set <= 1'b1; // RULE22
            end
          end
          SQ_KEYED: begin
            if (hit(paddr, OFS_MODE) &&
                (wd == MODE_SELF || wd == MODE_NORMAL)) begin
              seq_value <= wd; // RULE2 RULE4
              seq <= SQ_VALUE;
            end else begin
              seq_err_set <= 1'b1; // RULE22
              seq <= SQ_IDLE;
            end
          end
          SQ_VALUE: begin
            if (hit(paddr, OFS_MODE) && wd == ~seq_value) begin
              seq <= SQ_COMPL; // RULE2 RULE4
            end else begin
              seq_err_set <= 1'b1; // RULE22
              seq <= SQ_IDLE;
            end
          end
          default: begin
            if (hit(paddr, OFS_MODE) && wd == seq_value) begin
              self_prog_mode <= seq_value[0]; // RULE3 RULE5
            end else begin
              seq_err_set <= 1'b1; // RULE22
            end
            seq <= SQ_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // status register
  // ****************************************
  // writing 0 to a bit clears it; a set in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_status_reg <= RST_STATUS;
    end else begin
      if (hit(paddr, OFS_STATUS)) begin
        flash_status_reg <= flash_status_reg & wd[2:0];
      end
      if (seq_err_set) begin
        flash_status_reg[ST_SEQ_ERR] <= 1'b1; // RULE6
      end
      if (verify_set) begin
        flash_status_reg[ST_VERIFY_ERR] <= 1'b1; // RULE15
      end
      if (we_set) begin
        flash_status_reg[ST_WE_ERR] <= 1'b1; // RULE15
      end
    end
  end

  // ****************************************
  // operation sequencer
  // ****************************************
  // the cpu stays halted while busy; pointer and compare writes
  // are blocked then as well, since each write enable is gated with !busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op <= OP_IDLE;
      flash_erase <= 1'b0;
      flash_addr <= 12'h0;
      cpu_resume <= 1'b0;
      verify_set <= 1'b0;
      we_set <= 1'b0;
    end else begin
      cpu_resume <= 1'b0;
      verify_set <= 1'b0;
      we_set <= 1'b0;
      case (op)
        OP_IDLE: begin
          if (halt_req && self_prog_mode) begin // RULE14
            if (flash_command_reg == CMD_BLOCK_ERASE) begin // RULE12
              op <= OP_RUN;
              flash_erase <= 1'b1;
              flash_addr <= {ptr_hi[3:0], ptr_lo};
            end else begin
              if (flash_command_reg != CMD_NONE) begin
                verify_set <= 1'b1; // RULE20
                we_set <= 1'b1; // RULE20
              end
              op <= OP_DONE;
            end
          end
        end
        OP_RUN: begin
          flash_addr <= {ptr_hi[3:0], ptr_lo};
          if (flash_done) begin
            if (flash_err) begin
              we_set <= 1'b1; // RULE15
            end
            if (verify_err) begin
              verify_set <= 1'b1; // RULE15
            end
            if (match || flash_err) begin
              flash_erase <= 1'b0;
              op <= OP_DONE;
            end
          end
        end
        default: begin
          cpu_resume <= 1'b1; // RULE14
          op <= OP_IDLE;
        end
      endcase
    end
  end

  assign step = (op == OP_RUN) && flash_done && !match && !flash_err;

  fspm_addr_ctr u_addr_ctr (
    .clk(clk),
    .rst(rst),
    .wr_ptr_lo(hit(paddr, OFS_PTR_LO) && !busy),
    .wr_ptr_hi(hit(paddr, OFS_PTR_HI) && !busy),
    .wr_cmp_lo(hit(paddr, OFS_CMP_LO) && !busy),
    .wr_cmp_hi(hit(paddr, OFS_CMP_HI) && !busy),
    .wdata(wd),
    .step(step),
    .ptr_lo(ptr_lo),
    .ptr_hi(ptr_hi),
    .cmp_lo(cmp_lo),
    .cmp_hi(cmp_hi),
    .match(match)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_value_no_change: assert property ( // RULE2
    acc && (seq == SQ_KEYED || seq == SQ_VALUE) |=> $stable(self_prog_mode))
    else $error("mode changed before the third write");
  a_entry_third: assert property ( // RULE3
    wr && paddr == OFS_MODE && seq == SQ_COMPL && wd == MODE_SELF &&
    seq_value == MODE_SELF |=> self_prog_mode && !seq_err_set)
    else $error("entry sequence did not set mode");
  a_exit_third: assert property ( // RULE5
    wr && paddr == OFS_MODE && seq == SQ_COMPL && wd == MODE_NORMAL &&
    seq_value == MODE_NORMAL |=> !self_prog_mode)
    else $error("exit sequence did not clear mode");
  a_seq_err_flag: assert property ( // RULE6
    seq_err_set |=> flash_status_reg[ST_SEQ_ERR])
    else $error("sequence error not reported");
  a_abort_order: assert property ( // RULE22
    acc && seq == SQ_VALUE && !(wr && paddr == OFS_MODE) |=>
      seq == SQ_IDLE ##1 flash_status_reg[ST_SEQ_ERR])
    else $error("broken sequence not aborted");
  a_erase_start: assert property ( // RULE12
    op == OP_IDLE && halt_req && self_prog_mode &&
    flash_command_reg == CMD_BLOCK_ERASE |=> flash_erase && op == OP_RUN)
    else $error("block erase not started");
  a_halt_resume: assert property ( // RULE14
    op == OP_IDLE && halt_req && self_prog_mode &&
    flash_command_reg != CMD_BLOCK_ERASE |=> ##1 cpu_resume)
    else $error("no resume after halt");
  a_undef_cmd: assert property ( // RULE20
    op == OP_IDLE && halt_req && self_prog_mode &&
    flash_command_reg != CMD_BLOCK_ERASE && flash_command_reg != CMD_NONE
    |=> ##1 flash_status_reg[ST_VERIFY_ERR] && flash_status_reg[ST_WE_ERR])
    else $error("undefined command not flagged");
  a_erase_fail: assert property ( // RULE15
    op == OP_RUN && flash_done && flash_err |=>
      !flash_erase ##1 flash_status_reg[ST_WE_ERR] && cpu_resume)
    else $error("erase failure not flagged");
  a_normal_halt: assert property ( // RULE14
    halt_req && !self_prog_mode && op == OP_IDLE |=> op == OP_IDLE)
    else $error("operation started outside self mode");

  c_entry: cover property (seq == SQ_COMPL ##1 self_prog_mode);
  c_seq_err: cover property (seq_err_set);
  c_erase_done: cover property (op == OP_RUN && match && flash_done);
  c_exit: cover property ($fell(self_prog_mode));
endmodule

// ### tb_fspm_ctrl.sv
`timescale 1ns/1ps
module tb_fspm_ctrl;
  import fspm_pkg::*;
  // ****************************************
  // signals and model state
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic halt_req = 1'b0;
  logic flash_done = 1'b0;
  logic flash_err = 1'b0;
  logic verify_err = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic flash_erase;
  logic [11:0] flash_addr;
  logic cpu_resume;
  logic self_prog_mode;
  integer fail_count = 0;
  integer n_tests = 0;
  integer seed = 87349;
  logic [31:0] exp_st = 32'h0;
  logic exp_mode = 1'b0;
  logic [31:0] rd;
  logic er;
  logic [11:0] exp_addr;
  logic [7:0] hi;
  logic [7:0] clo;
  logic [7:0] u;
  integer e;

  fspm_ctrl fspm_ctrl_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_req(halt_req), .flash_done(flash_done),
    .flash_err(flash_err), .verify_err(verify_err),
    .flash_erase(flash_erase), .flash_addr(flash_addr),
    .cpu_resume(cpu_resume), .self_prog_mode(self_prog_mode)
  );

  // 25 MHz is above the 1 MHz floor and never changes across the run
  always #20 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends this wait if pready never rises
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic mode_pin;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, self_prog_mode}, {31'h0, exp_mode});
  endtask

  // bad key or bad complement must leave the mode alone and flag bit 0
  task automatic mode_seq(input logic [7:0] k, input logic [7:0] v,
                          input logic [7:0] c);
    wr(OFS_STATUS, 8'h00);
    exp_st = 32'h0;
    wr(OFS_KEY, k);
    wr(OFS_MODE, v);
    mode_pin();
    wr(OFS_MODE, c);
    mode_pin();
    wr(OFS_MODE, v);
    // no-op then halt before the result is read
    if (v == MODE_SELF) halt_pulse();
    if (k == KEY_VALUE && c == ~v) begin
      exp_mode = v[0];
    end else begin
      exp_st[ST_SEQ_ERR] = 1'b1;
    end
    mode_pin();
    rdchk(OFS_STATUS, exp_st);
  endtask

  task automatic halt_pulse;
    @(posedge clk);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] cmd, input logic [7:0] h,
                       input logic [7:0] cl);
    wr(OFS_CMD, cmd);
    wr(OFS_PTR_HI, h);
    wr(OFS_PTR_LO, 8'h00);
    wr(OFS_CMP_HI, h);
    wr(OFS_CMP_LO, cl);
    wr(OFS_STATUS, 8'h00);
    exp_st = 32'h0;
    rdchk(OFS_CMD, {24'h0, cmd});
    exp_addr = {h[3:0], 8'h00};
  endtask

  // ef: 1 verify failure on each step, 2 erase failure on the first
  task automatic run_op(input integer steps, input integer ef,
                        input logic und);
    integer i;
    integer j;
    // no watchdog is modelled and bench code never sits in the flash
    halt_pulse();
    for (i = 0; i < steps; i++) begin
      // the address output follows the pointer one cycle late
      if (i > 0) @(posedge clk);
      for (j = 0; j < 8 && flash_erase !== 1'b1; j++) @(posedge clk);
      chk({31'h0, flash_erase}, 32'h1);
      chk({20'h0, flash_addr}, {20'h0, exp_addr});
      flash_done <= 1'b1;
      verify_err <= (ef == 1);
      flash_err <= (ef == 2);
      @(posedge clk);
      flash_done <= 1'b0;
      verify_err <= 1'b0;
      flash_err <= 1'b0;
      if (ef == 1) exp_st[ST_VERIFY_ERR] = 1'b1;
      if (ef == 2) exp_st[ST_WE_ERR] = 1'b1;
      if (ef == 2) break;
      exp_addr = exp_addr + 12'h001;
      @(posedge clk);
    end
    if (und) exp_st = exp_st | 32'h6;
    for (j = 0; j < 12; j++) begin
      @(posedge clk);
      if (cpu_resume === 1'b1) break;
    end
    chk({31'h0, cpu_resume}, 32'h1);
    chk({31'h0, flash_erase}, 32'h0);
    rdchk(OFS_STATUS, exp_st);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    #(40 * 6000);
    fail_count++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({17'h0, flash_erase, cpu_resume, self_prog_mode, flash_addr}, 0);
    rdchk(OFS_STATUS, {29'h0, RST_STATUS});
    rdchk(OFS_CMD, {24'h0, RST_CMD});
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test reset and map done");
    // halt outside self-programming mode must not start anything
    halt_pulse();
    u = 8'h00;
    // the resume pulse lasts one cycle, so watch every edge
    repeat (8) begin
      @(posedge clk);
      u = u | {6'h0, cpu_resume, flash_erase};
    end
    chk({24'h0, u}, 32'h0);
    // the bench cpu has no interrupt source, so all stay masked
    wr(OFS_CMD, CMD_NONE);
    mode_seq(8'h5a, MODE_SELF, 8'hfe);
    mode_seq(KEY_VALUE, MODE_SELF, 8'hff);
    // a read inside the sequence breaks it
    wr(OFS_STATUS, 8'h00);
    wr(OFS_KEY, KEY_VALUE);
    wr(OFS_MODE, MODE_SELF);
    rdchk(OFS_CMD, {24'h0, CMD_NONE});
    wr(OFS_MODE, 8'hfe);
    wr(OFS_MODE, MODE_SELF);
    mode_pin();
    rdchk(OFS_STATUS, 32'h1);
    mode_seq(KEY_VALUE, MODE_SELF, 8'hfe);
    $display("test entry done");
    for (e = 0; e < 3; e++) begin
      hi = 8'($random(seed)) & 8'h0f;
      setup(CMD_BLOCK_ERASE, hi, 8'h00);
      run_op(1, e, 1'b0);
    end
    hi = 8'($random(seed)) & 8'h0f;
    clo = 8'($random(seed)) & 8'h03;
    setup(CMD_BLOCK_ERASE, hi, clo);
    run_op(clo + 1, 0, 1'b0);
    $display("test erase done");
    u = 8'($random(seed));
    if (u == CMD_NONE || u == CMD_BLOCK_ERASE) u = 8'h07;
    setup(u, 8'h00, 8'h00);
    run_op(0, 0, 1'b1);
    setup(CMD_NONE, 8'h00, 8'h00);
    run_op(0, 0, 1'b0);
    $display("test commands done");
    wr(OFS_CMD, CMD_NONE);
    mode_seq(KEY_VALUE, MODE_NORMAL, 8'h00);
    mode_seq(KEY_VALUE, MODE_NORMAL, 8'hff);
    $display("test exit done");
    close_out();
  end
endmodule
